/* File: design/timer_core_defs.svh */
// register offsets, field positions, reset values and timing counts of the timer core
`ifndef TIMER_CORE_DEFS_SVH
`define TIMER_CORE_DEFS_SVH

// byte offsets on the register bus
`define CTRL0_OFS      8'h00
`define CTRL1_OFS      8'h04
`define CNT_LO_OFS     8'h08
`define CNT_HI_OFS     8'h0C
`define CMPA_LO_OFS    8'h10
`define CMPA_HI_OFS    8'h14
`define CMPP_LO_OFS    8'h18
`define CMPP_HI_OFS    8'h1C
`define STATUS_OFS     8'h20
`define CAPT_OFS       8'h24

// control 0 fields
`define PAUSE_BIT      7
`define CKSEL_MSB      6
`define CKSEL_LSB      4
`define ON_BIT         3
// control 1 fields
`define MODE_MSB       7
`define MODE_LSB       6
`define PINF_MSB       5
`define PINF_LSB       4
`define INIT_LVL_BIT   3
`define POL_BIT        2
`define CAPSRC_BIT     1
`define CCLR_BIT       0

`define CTRL_RESET     8'h00
`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2

// clock divide counts
`define DIV_SYS4       8'h03
`define DIV_H16        8'h0F
`define DIV_H64        8'h3F

`endif

/* File: design/timer_core_pkg.sv */
// types shared by the timer core
package timer_core_pkg;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM     = 2'b10,
        MODE_TIMER   = 2'b11
    } op_mode_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } bus_state_type;

    typedef struct packed {
        bus_state_type wst;
        bus_state_type rst;
        logic          aw_seen;
        logic          w_seen;
        logic [7:0]    awaddr;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [1:0]    rresp;
        logic [31:0]   rdata;
        logic [7:0]    ctrl0;
        logic [7:0]    ctrl1;
        logic [15:0]   count;
        logic [15:0]   cmpa;
        logic [15:0]   cmpp;
        logic [15:0]   capt;
        logic [7:0]    low_buf;
        logic          on_d;
        logic [1:0]    ck_sync;
        logic          ck_d;
        logic [1:0]    cap_sync;
        logic          cap_d;
        logic [7:0]    div;
        logic          out_lvl;
        logic          pulse_run;
        logic          match_a;
        logic          match_p;
        logic          overflow;
        logic          capt_evt;
        logic          awready;
        logic          wready;
        logic          arready;
        logic          pin;
    } core_state_type;

endpackage : timer_core_pkg

/* File: design/timer_core.sv */
// timer core: count-up counter, two comparators, capture, output pin, AXI4-Lite slave
//
// Function
// - free-running counter compared with comparator values
// - match raises interrupt, may clear, drive pin
// - three-bit field selects counter clock source
// - separate interrupts for comparator A and P
// - clock, capture inputs, one output; edge selectable
// - single pulse mode triggered by external clock pin
// - capture on rising, falling or both edges
// - periodic type may capture from clock pin
// - compare match sets, clears or toggles pin
// - PWM waveform leaves on the same pin
// - edge aligned PWM, duty or period adjustable
// - high bytes direct, low bytes via buffer
// - buffer moves only on high byte access
// - low write fills buffer, high write commits
// - high read snapshots low byte into buffer
// - on-bit rising edge, overflow, match clear counter
// - mode field: compare, capture, PWM/pulse, timer
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "timer_core_defs.svh"

module timer_core
    import timer_core_pkg::*;
#(
    parameter bit PERIODIC = 1'b0    // periodic type: clock pin can capture
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        high_clk_en,     // internal_high_clock tick
    input  wire logic        sub_clk_en,      // sub_clock tick
    input  wire logic        ext_clock_pin,
    input  wire logic        capture_input_pin,
    output logic             timer_output_pin,
    output logic             irq_match_a,
    output logic             irq_match_p,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    core_state_type s_r;
    core_state_type s_nxt;

    // ----------------------------------------------------------------
    // derived control fields
    // ----------------------------------------------------------------
    op_mode_type mode;
    logic [2:0]  cksel;
    logic [1:0]  pinf;
    logic        on_bit;
    logic        paused;

    assign mode   = op_mode_type'(s_r.ctrl1[`MODE_MSB:`MODE_LSB]);
    assign cksel  = s_r.ctrl0[`CKSEL_MSB:`CKSEL_LSB];
    assign pinf   = s_r.ctrl1[`PINF_MSB:`PINF_LSB];
    assign on_bit = s_r.ctrl0[`ON_BIT];
    assign paused = s_r.ctrl0[`PAUSE_BIT];

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic        ck_rise;
    logic        ck_fall;
    logic        cap_rise;
    logic        cap_fall;
    logic        tick;
    logic        cap_hit;
    logic        hit_a;
    logic        hit_p;
    logic        wr_go;
    logic        rd_go;
    logic [7:0]  wbyte;
    logic        do_clear;
    logic        pulse_mode;

    always_comb begin
        s_nxt = s_r;
        cap_hit = 1'b0;

        // two-flop synchronisers, edges taken only from the second stage
        s_nxt.ck_sync  = {s_r.ck_sync[0], ext_clock_pin};
        s_nxt.ck_d     = s_r.ck_sync[1];
        s_nxt.cap_sync = {s_r.cap_sync[0], capture_input_pin};
        s_nxt.cap_d    = s_r.cap_sync[1];
        ck_rise  = s_r.ck_sync[1] & ~s_r.ck_d;
        ck_fall  = ~s_r.ck_sync[1] & s_r.ck_d;
        cap_rise = s_r.cap_sync[1] & ~s_r.cap_d;
        cap_fall = ~s_r.cap_sync[1] & s_r.cap_d;

        // counter clock selection; slower rates are enable pulses
        s_nxt.div = s_r.div + 8'h01;
        case (cksel)
            3'b000:  tick = (s_r.div[1:0] == 2'(`DIV_SYS4));
            3'b001:  tick = 1'b1;
            3'b010:  tick = high_clk_en & ((s_r.div & `DIV_H16) == `DIV_H16);
            3'b011:  tick = high_clk_en & ((s_r.div & `DIV_H64) == `DIV_H64);
            3'b100,
            3'b101:  tick = sub_clk_en;
            3'b110:  tick = ck_rise;
            default: tick = ck_fall;
        endcase
        if (cksel == 3'b010 || cksel == 3'b011) begin
            // the high-clock prescaler only advances on its own ticks
            s_nxt.div = high_clk_en ? s_r.div + 8'h01 : s_r.div;
        end

        pulse_mode = (mode == MODE_PWM) && (pinf == 2'b11);

        // comparators: A on all 16 bits, P on the top byte
        hit_a = on_bit && (s_r.count == s_r.cmpa);
        hit_p = on_bit && (s_r.count[15:8] == s_r.cmpp[7:0]);
        s_nxt.match_a  = 1'b0;
        s_nxt.match_p  = 1'b0;
        s_nxt.overflow = 1'b0;
        s_nxt.capt_evt = 1'b0;
        do_clear = 1'b0;

        // counter; single pulse waits for its trigger
        s_nxt.on_d = on_bit;
        if (on_bit && !s_r.on_d) begin
            s_nxt.count     = 16'h0000;
            s_nxt.out_lvl   = s_r.ctrl1[`INIT_LVL_BIT];
            s_nxt.pulse_run = 1'b0;
        end else if (on_bit && !paused && tick && (!pulse_mode || s_r.pulse_run)) begin
            // a match is seen on the counting edge, so each count value matches once
            if (hit_a) s_nxt.match_a = 1'b1;
            if (hit_p) s_nxt.match_p = 1'b1;
            do_clear = s_r.ctrl1[`CCLR_BIT] ? hit_a : hit_p;
            if (s_r.count == 16'hFFFF) s_nxt.overflow = 1'b1;
            s_nxt.count = do_clear ? 16'h0000 : s_r.count + 16'h0001;
        end

        // output pin behaviour per mode
        case (mode)
            MODE_COMPARE: begin
                if (s_nxt.match_a) begin
                    case (pinf)
                        2'b01:   s_nxt.out_lvl = 1'b0;
                        2'b10:   s_nxt.out_lvl = 1'b1;
                        2'b11:   s_nxt.out_lvl = ~s_r.out_lvl;
                        default: s_nxt.out_lvl = s_r.out_lvl;
                    endcase
                end
            end
            MODE_PWM: begin
                // edge aligned: active from period start to duty match
                case (pinf)
                    2'b00:   s_nxt.out_lvl = 1'b0;
                    2'b01:   s_nxt.out_lvl = 1'b1;
                    2'b10: begin
                        if (s_nxt.match_a) s_nxt.out_lvl = 1'b0;
                        else if (do_clear || s_nxt.overflow) s_nxt.out_lvl = 1'b1;
                    end
                    default: begin
                        // single pulse: trigger starts it, compare A ends it
                        if (!s_r.pulse_run && ck_rise && on_bit) begin
                            s_nxt.pulse_run = 1'b1;
                            s_nxt.out_lvl   = 1'b1;
                        end else if (s_r.pulse_run && s_nxt.match_a) begin
                            s_nxt.pulse_run = 1'b0;
                            s_nxt.out_lvl   = 1'b0;
                        end
                    end
                endcase
            end
            MODE_CAPTURE: begin
                // capture source: dedicated pin or clock pin on periodic type
                if (PERIODIC && s_r.ctrl1[`CAPSRC_BIT])
                    cap_hit = (pinf == 2'b00 && ck_rise) || (pinf == 2'b01 && ck_fall)
                           || (pinf == 2'b10 && (ck_rise || ck_fall));
                else
                    cap_hit = (pinf == 2'b00 && cap_rise) || (pinf == 2'b01 && cap_fall)
                           || (pinf == 2'b10 && (cap_rise || cap_fall));
                if (on_bit && cap_hit) begin
                    s_nxt.capt     = s_r.count;
                    s_nxt.capt_evt = 1'b1;
                    s_nxt.match_a  = 1'b1;
                end
            end
            default: ;
        endcase

        // ------------------------------------------------------------
        // AXI4-Lite write: address and data in either order
        // ------------------------------------------------------------
        if (s_axi_awvalid && !s_r.aw_seen && s_r.wst == BUS_IDLE) begin
            s_nxt.aw_seen = 1'b1;
            s_nxt.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.w_seen && s_r.wst == BUS_IDLE) begin
            s_nxt.w_seen = 1'b1;
            s_nxt.wdata  = s_axi_wdata;
            s_nxt.wstrb  = s_axi_wstrb;
        end
        wr_go = s_r.aw_seen && s_r.w_seen && s_r.wst == BUS_IDLE;
        wbyte = s_r.wdata[7:0];
        if (wr_go) begin
            s_nxt.aw_seen = 1'b0;
            s_nxt.w_seen  = 1'b0;
            s_nxt.wst     = BUS_RESP;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = `AXI_OKAY;
            if (s_r.wstrb[0]) begin
                if (s_r.awaddr == `CTRL0_OFS)
                    s_nxt.ctrl0 = {wbyte[7:3], 3'b000};
                else if (s_r.awaddr == `CTRL1_OFS)
                    s_nxt.ctrl1 = wbyte;
                else if (s_r.awaddr == `CMPA_LO_OFS || s_r.awaddr == `CMPP_LO_OFS)
                    s_nxt.low_buf = wbyte;
                else if (s_r.awaddr == `CMPA_HI_OFS)
                    s_nxt.cmpa = {wbyte, s_r.low_buf};
                else if (s_r.awaddr == `CMPP_HI_OFS)
                    s_nxt.cmpp = {wbyte, s_r.low_buf};
                else if (!(s_r.awaddr == `CNT_LO_OFS || s_r.awaddr == `CNT_HI_OFS
                           || s_r.awaddr == `STATUS_OFS || s_r.awaddr == `CAPT_OFS))
                    s_nxt.bresp = `AXI_SLVERR;
            end
        end
        if (s_r.wst == BUS_RESP && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.wst    = BUS_IDLE;
        end

        // ------------------------------------------------------------
        // AXI4-Lite read
        // ------------------------------------------------------------
        rd_go = s_axi_arvalid && s_r.rst == BUS_IDLE;
        if (rd_go) begin
            s_nxt.rst    = BUS_RESP;
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = `AXI_OKAY;
            s_nxt.rdata  = 32'h0000_0000;
            if (s_axi_araddr == `CTRL0_OFS)
                s_nxt.rdata[7:0] = s_r.ctrl0;
            else if (s_axi_araddr == `CTRL1_OFS)
                s_nxt.rdata[7:0] = s_r.ctrl1;
            else if (s_axi_araddr == `CNT_LO_OFS || s_axi_araddr == `CMPA_LO_OFS
                     || s_axi_araddr == `CMPP_LO_OFS)
                s_nxt.rdata[7:0] = s_r.low_buf;
            else if (s_axi_araddr == `CNT_HI_OFS) begin
                s_nxt.rdata[7:0] = s_r.count[15:8];
                s_nxt.low_buf    = s_r.count[7:0];
            end else if (s_axi_araddr == `CMPA_HI_OFS) begin
                s_nxt.rdata[7:0] = s_r.cmpa[15:8];
                s_nxt.low_buf    = s_r.cmpa[7:0];
            end else if (s_axi_araddr == `CMPP_HI_OFS) begin
                s_nxt.rdata[7:0] = s_r.cmpp[15:8];
                s_nxt.low_buf    = s_r.cmpp[7:0];
            end else if (s_axi_araddr == `STATUS_OFS)
                s_nxt.rdata[4:0] = {s_r.pulse_run, s_r.out_lvl, s_r.capt_evt, s_r.overflow, on_bit};
            else if (s_axi_araddr == `CAPT_OFS)
                s_nxt.rdata[15:0] = s_r.capt;
            else
                s_nxt.rresp = `AXI_SLVERR;
        end
        if (s_r.rst == BUS_RESP && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.rst    = BUS_IDLE;
        end

        // readies and pin level registered from the next state, so no output is combinational
        s_nxt.awready = s_nxt.wst == BUS_IDLE && !s_nxt.aw_seen;
        s_nxt.wready  = s_nxt.wst == BUS_IDLE && !s_nxt.w_seen;
        s_nxt.arready = s_nxt.rst == BUS_IDLE;
        s_nxt.pin     = s_nxt.out_lvl ^ s_nxt.ctrl1[`POL_BIT];   // polarity inverts the pin
    end

    // ----------------------------------------------------------------
    // state register, synchronous reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign timer_output_pin = s_r.pin;
    assign irq_match_a      = s_r.match_a;
    assign irq_match_p      = s_r.match_p;
    assign s_axi_awready    = s_r.awready;
    assign s_axi_wready     = s_r.wready;
    assign s_axi_bvalid     = s_r.bvalid;
    assign s_axi_bresp      = s_r.bresp;
    assign s_axi_arready    = s_r.arready;
    assign s_axi_rvalid     = s_r.rvalid;
    assign s_axi_rresp      = s_r.rresp;
    assign s_axi_rdata      = s_r.rdata;

endmodule : timer_core
`default_nettype wire

/* File: dv/timer_core_monitor.sv */
// bus timing and reset checker for the timer core
`timescale 1ns/10ps
`default_nettype none
`include "timer_core_defs.svh"
module timer_core_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // --------------------------------------------------------------
    // register bus properties, all in the one clock domain
    // --------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not two cycles after take");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address taken before answer");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `CAPT_OFS
        |=> s_axi_rresp == `AXI_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    a_mapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= `CAPT_OFS
        && s_axi_araddr[1:0] == 2'b00 |=> s_axi_rresp == `AXI_OKAY) else $error("mapped read refused");
    a_ready_release: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_wready && s_axi_arready)
        else $error("bus not ready after reset");
endmodule : timer_core_monitor

bind timer_core timer_core_monitor timer_core_monitor_inst (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking testbench for the timer core
`timescale 1ns/10ps
`default_nettype none
`include "timer_core_defs.svh"
module testbench;
    logic        aclk, aresetn, high_clk_en, sub_clk_en, ext_clock_pin, capture_input_pin;
    logic        timer_output_pin, irq_match_a, irq_match_p, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, lo, hi;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          failures, comparisons, cyc, na, np, pa_prev, pa_last, n0, k;
    int          seed = 55183;

    timer_core timer_core_inst (
        .aclk, .aresetn, .high_clk_en, .sub_clk_en, .ext_clock_pin, .capture_input_pin,
        .timer_output_pin, .irq_match_a, .irq_match_p, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    function automatic logic [33:0] okv(input logic [7:0] d);
        return {`AXI_OKAY, 24'h0, d};
    endfunction : okv

    // write one byte; ready sampled at negedge since it settles after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        logic aw_t, w_t, b_t;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid === 1'b1;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end while (!b_t);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        logic ar_t, r_t;
        rq.push_back(x);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid === 1'b1;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end while (!r_t);
    endtask : rd

    // one counting event; pin events are held long past the synchroniser
    task automatic tick(input int s);
        if (s > 5) begin
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            ext_clock_pin <= 1'b0;
        end else begin
            sub_clk_en <= 1'b1;
            @(posedge aclk);
            sub_clk_en <= 1'b0;
        end
        repeat (4) @(posedge aclk);
    endtask : tick

    task automatic wait_a(input int n);
        for (int i = 0; i < 200 && na < n; i++) @(posedge aclk);
    endtask : wait_a

    // clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // observer: interrupt pulses, queued bus answers, timeout
    always @(posedge aclk) begin
        cyc++;
        if (irq_match_a === 1'b1) begin
            na++;
            pa_prev = pa_last;
            pa_last = cyc;
        end
        if (irq_match_p === 1'b1) np++;
        if (s_axi_rvalid === 1'b1 && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()));
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    // main sequence
    initial begin
        {aresetn, high_clk_en, sub_clk_en, ext_clock_pin, capture_input_pin} = '0; // pins routed
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CTRL0_OFS, okv(8'h00));
        rd(`CTRL1_OFS, okv(8'h00));
        rd(8'h28, {`AXI_SLVERR, 32'h0});
        wr(8'h28, 8'h55, `AXI_SLVERR);
        $display("done reset_map");
        lo = 8'($random(seed));
        hi = 8'($random(seed));
        wr(`CMPA_LO_OFS, lo, `AXI_OKAY);
        rd(`CMPA_HI_OFS, okv(8'h00));
        rd(`CMPA_LO_OFS, okv(8'h00));
        wr(`CMPA_LO_OFS, lo, `AXI_OKAY);
        wr(`CMPA_HI_OFS, hi, `AXI_OKAY);
        rd(`CMPA_HI_OFS, okv(hi));
        rd(`CMPA_LO_OFS, okv(lo));
        wr(`CMPP_LO_OFS, hi, `AXI_OKAY);
        wr(`CMPP_HI_OFS, lo, `AXI_OKAY);
        rd(`CMPP_HI_OFS, okv(lo));
        rd(`CMPP_LO_OFS, okv(hi));
        $display("done byte_buffer");
        // top compare value kept out of reach so no clear during counting
        wr(`CMPP_LO_OFS, 8'hFF, `AXI_OKAY);
        wr(`CMPP_HI_OFS, 8'hFF, `AXI_OKAY);
        for (int s = 4; s < 8; s++) begin
            k = 1 + ($random(seed) & 7);
            wr(`CTRL0_OFS, 8'(s << 4), `AXI_OKAY);
            wr(`CTRL0_OFS, 8'((s << 4) | 8), `AXI_OKAY);
            repeat (k) tick(s);
            wr(`CTRL0_OFS, 8'(s << 4), `AXI_OKAY);
            rd(`CNT_HI_OFS, okv(8'h00));
            rd(`CNT_LO_OFS, okv(8'(k)));
        end
        $display("done clock_sources");
        wr(`CTRL0_OFS, 8'h10, `AXI_OKAY);
        wr(`CMPA_LO_OFS, 8'd20, `AXI_OKAY);
        wr(`CMPA_HI_OFS, 8'h00, `AXI_OKAY);
        for (int p = 1; p < 4; p++) begin
            wr(`CTRL1_OFS, {4'(p), p == 1, 3'b001}, `AXI_OKAY);
            wr(`CTRL0_OFS, 8'h18, `AXI_OKAY);
            @(posedge aclk); // initial level lands on the edge that ends the write
            check(34'(timer_output_pin), 34'(p == 1));
            wait_a(na + 2);
            repeat (3) @(posedge aclk);
            check(34'(pa_last - pa_prev), 34'd21);
            check(34'(timer_output_pin), 34'(p == 2));
            wr(`CTRL0_OFS, 8'h10, `AXI_OKAY);
        end
        $display("done compare_a");
        wr(`CTRL1_OFS, 8'h00, `AXI_OKAY);
        wr(`CMPP_LO_OFS, 8'h01, `AXI_OKAY);
        wr(`CMPP_HI_OFS, 8'h00, `AXI_OKAY);
        n0 = np;
        wr(`CTRL0_OFS, 8'h18, `AXI_OKAY);
        repeat (300) @(posedge aclk);
        check(34'(np - n0), 34'd1);
        wr(`CTRL0_OFS, 8'h40, `AXI_OKAY);
        $display("done compare_p");
        // sub clock held still so only capture events raise the interrupt
        for (int p = 0; p < 4; p++) begin
            wr(`CTRL1_OFS, {2'b01, 2'(p), 4'h0}, `AXI_OKAY);
            wr(`CTRL0_OFS, 8'h48, `AXI_OKAY);
            n0 = na;
            repeat (2) begin
                capture_input_pin <= 1'b1;
                repeat (4) @(posedge aclk);
                capture_input_pin <= 1'b0;
                repeat (4) @(posedge aclk);
            end
            repeat (4) @(posedge aclk);
            check(34'(na - n0), (p == 3) ? 34'd0 : (p == 2) ? 34'd4 : 34'd2);
            wr(`CTRL0_OFS, 8'h40, `AXI_OKAY);
        end
        $display("done capture");
        wr(`CTRL0_OFS, 8'h10, `AXI_OKAY);
        wr(`CTRL1_OFS, 8'hB0, `AXI_OKAY);
        wr(`CTRL0_OFS, 8'h18, `AXI_OKAY);
        check(34'(timer_output_pin), 34'd0);
        tick(6);
        check(34'(timer_output_pin), 34'd1);
        repeat (40) @(posedge aclk);
        check(34'(timer_output_pin), 34'd0);
        $display("done single_pulse");
        // edge aligned PWM: period from P, duty from A, pin inverted by polarity
        wr(`CTRL0_OFS, 8'h10, `AXI_OKAY);
        wr(`CTRL1_OFS, 8'hA4, `AXI_OKAY);
        wr(`CTRL0_OFS, 8'h18, `AXI_OKAY);
        repeat (265) @(posedge aclk);
        check(34'(timer_output_pin), 34'd0);
        repeat (20) @(posedge aclk);
        check(34'(timer_output_pin), 34'd1);
        $display("done pwm");
        results();
    end
endmodule : testbench
`default_nettype wire
